// ==== rtl/cdr_pkg.sv ====
// Package for the channel diagnostic record: offsets, field layout, constants.
// Assumes a 10 MHz reference clock and a byte-wide record read port.
package cdr_pkg;

  // ---------------------------------------------------------------
  // Record byte offsets (subindex of each byte)
  // ---------------------------------------------------------------
  localparam logic [7:0] CDR_OFS_MOD_DIAG_SEC  = 8'h05;
  localparam logic [7:0] CDR_OFS_CHAN_TYPE     = 8'h06;
  localparam logic [7:0] CDR_OFS_DIAG_BITS     = 8'h07;
  localparam logic [7:0] CDR_OFS_CHAN_COUNT    = 8'h08;
  localparam logic [7:0] CDR_OFS_GROUP_ERR     = 8'h09;
  localparam logic [7:0] CDR_OFS_CH0_ERR       = 8'h0A;
  localparam logic [7:0] CDR_OFS_CH1_ERR       = 8'h0B;
  localparam logic [7:0] CDR_OFS_UNUSED_FIRST  = 8'h0C;
  localparam logic [7:0] CDR_OFS_UNUSED_LAST   = 8'h11;
  localparam logic [7:0] CDR_OFS_STAMP         = 8'h13;
  localparam int         CDR_STAMP_BYTES       = 4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CDR_BIT_BUF_OVF      = 3;
  localparam int CDR_BIT_COMM_ERR     = 4;
  localparam int CDR_BIT_IRQ_LOST_MOD = 6;
  localparam int CDR_BIT_PARAM_ERR    = 0;
  localparam int CDR_BIT_WIRE_BREAK   = 4;
  localparam int CDR_BIT_IRQ_LOST_CH  = 5;
  localparam int CDR_BIT_UNDERFLOW    = 6;
  localparam int CDR_BIT_OVERFLOW     = 7;

  // ---------------------------------------------------------------
  // Constant and reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] CDR_TYPE_DIG_IN   = 7'h70;
  localparam logic [6:0] CDR_TYPE_ANA_IN   = 7'h71;
  localparam logic [6:0] CDR_TYPE_DIG_OUT  = 7'h72;
  localparam logic [6:0] CDR_TYPE_ANA_OUT  = 7'h73;
  localparam logic [6:0] CDR_TYPE_ANA_IO   = 7'h74;
  localparam logic [6:0] CDR_TYPE_COUNTER  = 7'h76;
  localparam logic [7:0] CDR_DIAG_BITS_VAL = 8'h08;
  localparam logic [7:0] CDR_CHAN_CNT_VAL  = 8'h02;
  localparam logic [7:0] CDR_BYTE_RESET    = 8'h00;
  localparam logic [31:0] CDR_STAMP_RESET  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CDR_CLK_HZ      = 10_000_000;
  localparam int CDR_TICK_NS     = 1000;
  localparam int CDR_TICK_CYCLES = CDR_TICK_NS / (1_000_000_000 / CDR_CLK_HZ);
  localparam logic [3:0] CDR_TICK_LAST = 4'(CDR_TICK_CYCLES - 1);

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic param_err;
    logic wire_break;
    logic irq_lost;
    logic underflow;
    logic overflow;
  } cdr_chan_evt_type;

  typedef struct packed {
    logic buf_ovf;
    logic comm_err;
    logic irq_lost;
  } cdr_mod_evt_type;

  typedef struct packed {
    logic       rd_en;
    logic [7:0] addr;
  } cdr_rd_req_type;

endpackage

// ==== rtl/cdr_record.sv ====
// Channel diagnostic record of a two-channel analog input module.
// Assumes event inputs come from logic on ref_clk; reads from the bus master
// side are single-cycle byte reads on the same clock.
module cdr_record
  import cdr_pkg::*;
#(
  parameter logic [6:0] CHAN_TYPE = CDR_TYPE_ANA_IN
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire cdr_mod_evt_type  mod_evt,
  input  wire cdr_chan_evt_type ch0_evt,
  input  wire cdr_chan_evt_type ch1_evt,
  input  wire cdr_rd_req_type   rd_req,
  output logic [7:0]            rd_data,
  output logic                  rd_valid,
  output logic                  diag_active,
  output logic                  diag_incoming,
  output logic                  diag_going
);

  // ---------------------------------------------------------------
  // Microsecond time base
  // ---------------------------------------------------------------
  logic [3:0]  tick_cnt_q, tick_cnt_d;
  logic        us_tick;
  logic [31:0] us_count_q, us_count_d;

  always_comb begin
    us_tick    = (tick_cnt_q == CDR_TICK_LAST);
    tick_cnt_d = us_tick ? 4'h0 : 4'(tick_cnt_q + 4'h1);
    us_count_d = us_tick ? 32'(us_count_q + 32'h0000_0001) : us_count_q;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 4'h0;
      us_count_q <= CDR_STAMP_RESET;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      us_count_q <= us_count_d;
    end
  end

  // ---------------------------------------------------------------
  // Diagnostic state: window opens on the first error and closes
  // when every error cause is gone
  // ---------------------------------------------------------------
  function automatic logic [7:0] chan_byte(input cdr_chan_evt_type e);
    logic [7:0] b;
    b = 8'h00;
    b[CDR_BIT_PARAM_ERR]   = e.param_err;
    b[CDR_BIT_WIRE_BREAK]  = e.wire_break;
    b[CDR_BIT_IRQ_LOST_CH] = e.irq_lost;
    b[CDR_BIT_UNDERFLOW]   = e.underflow;
    b[CDR_BIT_OVERFLOW]    = e.overflow;
    return b;
  endfunction

  logic [7:0]  mod_sec_q, mod_sec_d;
  logic [7:0]  ch0_err_q, ch0_err_d;
  logic [7:0]  ch1_err_q, ch1_err_d;
  logic [31:0] stamp_q, stamp_d;
  logic        active_q, active_d;
  logic [7:0]  mod_now, ch0_now, ch1_now;
  logic        any_err;

  always_comb begin
    mod_now = 8'h00;
    mod_now[CDR_BIT_BUF_OVF]      = mod_evt.buf_ovf;
    mod_now[CDR_BIT_COMM_ERR]     = mod_evt.comm_err;
    mod_now[CDR_BIT_IRQ_LOST_MOD] = mod_evt.irq_lost;
    ch0_now = chan_byte(ch0_evt);
    ch1_now = chan_byte(ch1_evt);
    any_err = |{mod_now, ch0_now, ch1_now};

    mod_sec_d = mod_sec_q;
    ch0_err_d = ch0_err_q;
    ch1_err_d = ch1_err_q;
    stamp_d   = stamp_q;
    active_d  = active_q;
    diag_incoming = 1'b0;
    diag_going    = 1'b0;

    if (!active_q) begin
      if (any_err) begin
        // Freeze record contents at the incoming diagnostic
        mod_sec_d     = mod_now;
        ch0_err_d     = ch0_now;
        ch1_err_d     = ch1_now;
        stamp_d       = us_count_q;
        active_d      = 1'b1;
        diag_incoming = 1'b1;
      end
    end else if (!any_err) begin
      // Going diagnostic records the clearing and its time
      mod_sec_d  = 8'h00;
      ch0_err_d  = 8'h00;
      ch1_err_d  = 8'h00;
      stamp_d    = us_count_q;
      active_d   = 1'b0;
      diag_going = 1'b1;
    end
    // Otherwise new channel events inside the window are dropped
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mod_sec_q <= CDR_BYTE_RESET;
      ch0_err_q <= CDR_BYTE_RESET;
      ch1_err_q <= CDR_BYTE_RESET;
      stamp_q   <= CDR_STAMP_RESET;
      active_q  <= 1'b0;
    end else begin
      mod_sec_q <= mod_sec_d;
      ch0_err_q <= ch0_err_d;
      ch1_err_q <= ch1_err_d;
      stamp_q   <= stamp_d;
      active_q  <= active_d;
    end
  end

  assign diag_active = active_q;

  // ---------------------------------------------------------------
  // Record read port
  // ---------------------------------------------------------------
  logic [7:0] rd_data_q, rd_data_d;
  logic       rd_valid_q, rd_valid_d;
  logic [7:0] group_err;
  logic [7:0] stamp_idx;

  always_comb begin
    group_err    = 8'h00;
    group_err[0] = |ch0_err_q;
    group_err[1] = |ch1_err_q;
    stamp_idx    = 8'(rd_req.addr - CDR_OFS_STAMP);
    rd_valid_d   = rd_req.rd_en;
    rd_data_d    = rd_data_q;
    if (rd_req.rd_en) begin
      unique case (rd_req.addr)
        CDR_OFS_MOD_DIAG_SEC: rd_data_d = mod_sec_q;
        CDR_OFS_CHAN_TYPE:    rd_data_d = {1'b0, CHAN_TYPE};
        CDR_OFS_DIAG_BITS:    rd_data_d = CDR_DIAG_BITS_VAL;
        CDR_OFS_CHAN_COUNT:   rd_data_d = CDR_CHAN_CNT_VAL;
        CDR_OFS_GROUP_ERR:    rd_data_d = group_err;
        CDR_OFS_CH0_ERR:      rd_data_d = ch0_err_q;
        CDR_OFS_CH1_ERR:      rd_data_d = ch1_err_q;
        default: begin
          if (stamp_idx < 8'(CDR_STAMP_BYTES)) begin
            rd_data_d = stamp_q[stamp_idx[1:0]*8 +: 8];
          end else begin
            rd_data_d = 8'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q  <= CDR_BYTE_RESET;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

endmodule

// ==== test/cdr_bus_master.sv ====
// Bus master model: single byte reads of the record.
// Drives the strobe 1 ns after the clock edge.
module cdr_bus_master
  import cdr_pkg::*;
(
  input  wire logic       ref_clk,
  output cdr_rd_req_type  rd_req,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rd_req = '{1'b0, 8'h00};
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int n;
    @(posedge ref_clk) #1 rd_req = '{1'b1, a};
    // Idle address flipped so it is never mistaken for live
    @(posedge ref_clk) #1 rd_req = '{1'b0, ~a};
    for (n = 0; n < 4 && rd_valid !== 1'b1; n++) @(posedge ref_clk) #1;
    ok = rd_valid === 1'b1;
    d = rd_data;
  endtask
endmodule

// ==== test/cdr_record_checker.sv ====
// Checker for the record read port and the diagnostic window.
// Bound to cdr_record below; sees its ports only.
module cdr_record_checker
  import cdr_pkg::*;
#(
  parameter logic [6:0] CHAN_TYPE = CDR_TYPE_ANA_IN
) (
  input wire logic             ref_clk,
  input wire logic             rst_b,
  input wire cdr_mod_evt_type  mod_evt,
  input wire cdr_chan_evt_type ch0_evt,
  input wire cdr_chan_evt_type ch1_evt,
  input wire cdr_rd_req_type   rd_req,
  input wire logic [7:0]       rd_data,
  input wire logic             rd_valid,
  input wire logic             diag_active,
  input wire logic             diag_incoming,
  input wire logic             diag_going
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire any_evt = |{mod_evt, ch0_evt, ch1_evt};
  sequence s_rd(a);
    rd_req.rd_en && rd_req.addr == a;
  endsequence
  property p_valid; rd_req.rd_en |=> rd_valid; endproperty
  property p_quiet; !rd_req.rd_en |=> !rd_valid; endproperty
  property p_open; !diag_active && any_evt |-> diag_incoming ##1 diag_active; endproperty
  property p_close; diag_active && !any_evt |-> diag_going ##1 !diag_active; endproperty
  property p_type; s_rd(CDR_OFS_CHAN_TYPE) |=> rd_data == {1'b0, CHAN_TYPE}; endproperty
  property p_bits; s_rd(CDR_OFS_DIAG_BITS) |=> rd_data == 8'h08; endproperty
  property p_count; s_rd(CDR_OFS_CHAN_COUNT) |=> rd_data == 8'h02; endproperty
  property p_unused;
    rd_req.rd_en && rd_req.addr inside {[8'h0C:8'h11]} |=> rd_data == 8'h00;
  endproperty
  a_valid: assert property (p_valid) else $error("read not answered");
  a_quiet: assert property (p_quiet) else $error("answer without read");
  a_open: assert property (p_open) else $error("window did not open");
  a_close: assert property (p_close) else $error("window did not close");
  a_type: assert property (p_type) else $error("bad type byte");
  a_bits: assert property (p_bits) else $error("bad bit count");
  a_count: assert property (p_count) else $error("bad channel count");
  a_unused: assert property (p_unused) else $error("unused byte set");
endmodule

bind cdr_record cdr_record_checker #(.CHAN_TYPE(CHAN_TYPE)) cdr_record_checker_inst (
  .ref_clk(ref_clk), .rst_b(rst_b), .mod_evt(mod_evt), .ch0_evt(ch0_evt),
  .ch1_evt(ch1_evt), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
  .diag_active(diag_active), .diag_incoming(diag_incoming), .diag_going(diag_going));

// ==== test/test_channel_diagnostic_record.sv ====
// Self-checking bench for the diagnostic record.
// Needs cdr_record, its checker and the bus master model.
module test_channel_diagnostic_record
  import cdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             ref_clk = 0;
  logic             rst_b = 0;
  cdr_mod_evt_type  mod_evt = '0;
  cdr_chan_evt_type ch0_evt = '0, ch1_evt = '0;
  cdr_rd_req_type   rd_req;
  logic [7:0]       rd_data, d;
  logic             rd_valid, diag_active, diag_incoming, diag_going;
  logic [31:0]      st;
  int               errors = 0, tests_run = 0, cyc = 0, inc_cyc = 0;
  logic [7:0]       pos [5] = '{8'h01, 8'h10, 8'h20, 8'h40, 8'h80};
  `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rst_b) cyc <= cyc + 1;
  always @(posedge ref_clk) if (diag_incoming) inc_cyc <= cyc;
  cdr_record cdr_record_inst (.ref_clk(ref_clk), .rst_b(rst_b), .mod_evt(mod_evt),
    .ch0_evt(ch0_evt), .ch1_evt(ch1_evt), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .diag_active(diag_active), .diag_incoming(diag_incoming),
    .diag_going(diag_going));
  cdr_bus_master cdr_bus_master_inst (.ref_clk(ref_clk), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd_byte(logic [7:0] a);
    bit ok;
    cdr_bus_master_inst.rd(a, d, ok);
    if (!ok) begin errors++; end_sim; end
  endtask
  task automatic ev(cdr_mod_evt_type m, cdr_chan_evt_type c0, cdr_chan_evt_type c1);
    @(posedge ref_clk) #1 {mod_evt, ch0_evt, ch1_evt} = {m, c0, c1};
  endtask
  task automatic wait_act(logic v);
    int n;
    for (n = 0; n < 20 && diag_active !== v; n++) @(posedge ref_clk) #1;
    if (diag_active !== v) begin errors++; end_sim; end
  endtask
  task automatic t_const;
    rd_byte(CDR_OFS_CHAN_TYPE); `CHK(d, 8'h71)
    rd_byte(CDR_OFS_DIAG_BITS); `CHK(d, 8'h08)
    rd_byte(CDR_OFS_CHAN_COUNT); `CHK(d, 8'h02)
    for (int a = 5; a <= 'h12; a++) if (!(a inside {6, 7, 8})) begin
      rd_byte(8'(a)); `CHK(d, 8'h00)
    end
    rd_byte(8'hFF); `CHK(d, 8'h00)
    $display("constant bytes done");
  endtask
  task automatic t_mod;
    logic [7:0] exp [3] = '{8'h08, 8'h10, 8'h40};
    for (int i = 0; i < 3; i++) begin
      ev(3'b100 >> i, '0, '0);
      wait_act(1);
      rd_byte(CDR_OFS_MOD_DIAG_SEC); `CHK(d, exp[i])
      for (int j = 0; j < 4; j++) begin
        rd_byte(CDR_OFS_STAMP + 8'(j));
        st[8*j+:8] = d;
      end
      `CHK(st - 32'(inc_cyc / 10) + 32'd1 <= 32'd2, 1'b1)
      ev('0, '0, '0);
      wait_act(0);
    end
    $display("module flags done");
  endtask
  task automatic t_chan;
    cdr_chan_evt_type e;
    for (int c = 0; c < 2; c++) for (int k = 0; k < 5; k++) begin
      e = 5'b10000 >> k;
      ev('0, c ? '0 : e, c ? e : '0);
      wait_act(1);
      ev('0, c ? 5'h1F : e, c ? e : 5'h1F);
      rd_byte(CDR_OFS_CH0_ERR + 8'(c)); `CHK(d, pos[k])
      rd_byte(CDR_OFS_CH1_ERR - 8'(c)); `CHK(d, 8'h00)
      rd_byte(CDR_OFS_GROUP_ERR); `CHK(d, 8'h01 << c)
      ev('0, '0, '0);
      wait_act(0);
      rd_byte(CDR_OFS_GROUP_ERR); `CHK(d, 8'h00)
    end
    $display("channel flags done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst_b = 1;
    t_const;
    t_mod;
    t_chan;
    end_sim;
  end
endmodule
